// ### logic/eidf_consts.svh
/*
 * Constants of the extended-identifier acceptance filter: register
 * offsets, field positions, reset values and encodings.
 * Assumes it is included by its bare name from design files only.
 */
`ifndef EIDF_CONSTS_SVH
`define EIDF_CONSTS_SVH

// ==========================================================
// register offsets (byte addresses, low 12 bits of haddr)
`define EIDF_OFS_LIST_CFG     12'h000
`define EIDF_OFS_GLOBAL_MASK  12'h004
`define EIDF_OFS_IRQ_STATUS   12'h008
`define EIDF_OFS_IRQ_ENABLE   12'h00C
`define EIDF_OFS_HPM_STATUS   12'h010
`define EIDF_OFS_LAST_RESULT  12'h014
`define EIDF_RAM_WINDOW_SEL   2'h1

// ==========================================================
// list configuration fields
`define EIDF_LCFG_START_MSB   7
`define EIDF_LCFG_START_LSB   0
`define EIDF_LCFG_SIZE_MSB    22
`define EIDF_LCFG_SIZE_LSB    16

// ==========================================================
// interrupt status / enable bit positions
`define EIDF_IRQ_HPM          0
`define EIDF_IRQ_DONE         1
`define EIDF_IRQ_MISS         2
`define EIDF_IRQ_BITS         3

// ==========================================================
// element configuration and match type codes
`define EIDF_CFG_DISABLED     3'h0
`define EIDF_CFG_FIFO0        3'h1
`define EIDF_CFG_FIFO1        3'h2
`define EIDF_CFG_REJECT       3'h3
`define EIDF_CFG_PRIO         3'h4
`define EIDF_CFG_PRIO_FIFO0   3'h5
`define EIDF_CFG_PRIO_FIFO1   3'h6
`define EIDF_CFG_BUFFER       3'h7
`define EIDF_TYPE_RANGE       2'h0
`define EIDF_TYPE_DUAL        2'h1
`define EIDF_TYPE_CLASSIC     2'h2
`define EIDF_TYPE_RANGE_RAW   2'h3

// ==========================================================
// second identifier fields for buffer / debug elements
`define EIDF_ID2_KIND_MSB     10
`define EIDF_ID2_KIND_LSB     9
`define EIDF_ID2_EVT_MSB      8
`define EIDF_ID2_EVT_LSB      6
`define EIDF_ID2_OFS_MSB      5
`define EIDF_ID2_OFS_LSB      0

// ==========================================================
// high priority status storage indication and reset values
`define EIDF_MSI_NONE         2'h0
`define EIDF_MSI_FIFO0        2'h2
`define EIDF_MSI_FIFO1        2'h3
`define EIDF_RST_GLOBAL_MASK  29'h1FFF_FFFF
`define EIDF_RST_START        8'h00
`define EIDF_RST_SIZE         7'h00

`endif

// ### logic/eidf_pkg.sv
/*
 * Types of the extended-identifier acceptance filter.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package eidf_pkg;

    // ==========================================================
    // state machines, gray along the usual path
    typedef enum logic [1:0] {
        BUS_IDLE = 2'h0,
        BUS_WAIT = 2'h1,
        BUS_LOAD = 2'h3,
        BUS_DONE = 2'h2
    } bus_state_type;

    typedef enum logic [1:0] {
        SCAN_IDLE   = 2'h0,
        SCAN_FETCH0 = 2'h1,
        SCAN_FETCH1 = 2'h3,
        SCAN_CHECK  = 2'h2
    } scan_state_type;

    typedef enum logic [2:0] {
        DEST_NONE    = 3'h0,
        DEST_FIFO0   = 3'h1,
        DEST_FIFO1   = 3'h2,
        DEST_RXBUF   = 3'h3,
        DEST_DEBUG_A = 3'h4,
        DEST_DEBUG_B = 3'h5,
        DEST_DEBUG_C = 3'h6
    } dest_type;

    // ==========================================================
    // one filter element: word 0 then word 1
    typedef struct packed {
        logic [2:0]  ext_element_config;
        logic [28:0] ext_first_identifier;
        logic [1:0]  ext_match_type;
        logic        spare;
        logic [28:0] ext_second_identifier;
    } element_type;

    typedef struct packed {
        logic       matched;
        logic       accepted;
        logic       priority_hit;
        dest_type   dest;
        logic [5:0] index;
        logic [5:0] buf_offset;
    } filter_result_type;

    typedef struct packed {
        logic        write;
        logic [11:0] addr;
    } ahb_req_type;

endpackage

// ### logic/filter_ram.sv
/*
 * Message RAM holding the filter elements: one write port, one read
 * port with registered read data (one cycle latency).
 * Assumes a single clock; clk_en low freezes writes and read data.
 */
`timescale 1ns/100ps

module filter_ram #(
    parameter int DATA_W = 32,
    parameter int DEPTH  = 256,
    parameter int ADDR_W = $clog2(DEPTH)
) (
    input  wire logic              clk_sys,
    input  wire logic              clk_en,
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic              rd_en,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic      [DATA_W-1:0] rd_data_ff
);

    // ==========================================================
    // storage; contents are undefined until software writes them
    logic [DATA_W-1:0] mem [DEPTH];

    always_ff @(posedge clk_sys) begin
        if (clk_en && wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        if (clk_en && rd_en) begin
            rd_data_ff <= mem[rd_addr];
        end
    end

endmodule

// ### logic/extended_id_acceptance_filter.sv
/*
 * Extended-identifier acceptance filter with AHB-Lite register and
 * message RAM access, element scanner and level interrupt.
 * Assumes the receive path runs on clk_sys and holds rx_id with
 * id_valid until id_ready; software fills elements before use.
 */
`timescale 1ns/100ps
`include "eidf_consts.svh"

module extended_id_acceptance_filter
    import eidf_pkg::*;
#(
    parameter int NUM_ELEMENTS = 64,
    parameter int RAM_DEPTH    = 256
) (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    input  wire logic        id_valid,
    input  wire logic [28:0] rx_id,
    output logic             id_ready,
    output logic             result_valid,
    output filter_result_type result,
    output logic      [2:0]  filter_event,
    output logic             irq
);

    localparam int AW = $clog2(RAM_DEPTH);

    // ==========================================================
    // elaboration checks
    if (NUM_ELEMENTS < 1 || NUM_ELEMENTS > 64) begin : g_bad_elements
        $error("NUM_ELEMENTS must lie in 1..64");
    end
    if (RAM_DEPTH < 2 || RAM_DEPTH > 256 || (1 << AW) != RAM_DEPTH)
    begin : g_bad_depth
        $error("RAM_DEPTH must be a power of two up to 256");
    end

    // ==========================================================
    // declarations
    bus_state_type     bus_st_ff, nxt_bus_st;
    ahb_req_type       req_ff, nxt_req;
    logic [31:0]       hrdata_ff, nxt_hrdata;
    scan_state_type    scan_st_ff, nxt_scan_st;
    logic [6:0]        idx_ff, nxt_idx;
    logic [28:0]       id_ff, nxt_id;
    logic [31:0]       w0_ff, nxt_w0;
    logic              result_valid_ff, nxt_result_valid;
    filter_result_type result_ff, nxt_result;
    logic [2:0]        event_ff, nxt_event;
    logic [7:0]        start_ff, nxt_start;
    logic [6:0]        size_ff, nxt_size;
    logic [28:0]       gmask_ff, nxt_gmask;
    logic [`EIDF_IRQ_BITS-1:0] ist_ff, nxt_ist, ien_ff, nxt_ien;
    logic [7:0]        hpm_status_ff, nxt_hpm_status;
    logic [`EIDF_IRQ_BITS-1:0] evt_set;
    logic              is_ram, bus_ram_req, bus_ram_take, reg_wr;
    logic              scan_rd;
    logic [AW-1:0]     scan_addr, ram_raddr;
    logic [31:0]       ram_rdata, reg_rdata;
    logic [6:0]        size_eff;
    element_type       elem;
    logic              hit;
    filter_result_type action;

    // ==========================================================
    // AHB-Lite slave
    // window 0x400..0x7FF maps the message RAM, one word per four byte addresses
    assign is_ram       = (req_ff.addr[11:10] == `EIDF_RAM_WINDOW_SEL);
    assign bus_ram_req  = (bus_st_ff == BUS_WAIT) && !req_ff.write
                          && is_ram;
    // the scanner owns the port while fetching word 1 of an element
    assign bus_ram_take = bus_ram_req && (scan_st_ff != SCAN_FETCH1);
    assign reg_wr       = (bus_st_ff == BUS_WAIT) && req_ff.write;
    assign hreadyout    = (bus_st_ff == BUS_IDLE)
                          || (bus_st_ff == BUS_DONE);
    assign hresp        = 1'b0;
    assign hrdata       = hrdata_ff;

    always_comb begin
        nxt_bus_st = bus_st_ff;
        nxt_req    = req_ff;
        nxt_hrdata = hrdata_ff;
        unique case (bus_st_ff)
            BUS_IDLE, BUS_DONE: begin
                if (hsel && hready && htrans[1]) begin
                    nxt_req.write = hwrite;
                    nxt_req.addr  = haddr[11:0];
                    nxt_bus_st    = BUS_WAIT;
                end else begin
                    nxt_bus_st = BUS_IDLE;
                end
            end
            BUS_WAIT: begin
                if (req_ff.write) begin
                    nxt_bus_st = BUS_DONE;
                end else if (!is_ram) begin
                    nxt_hrdata = reg_rdata;
                    nxt_bus_st = BUS_DONE;
                end else if (bus_ram_take) begin
                    nxt_bus_st = BUS_LOAD;
                end
            end
            BUS_LOAD: begin
                nxt_hrdata = ram_rdata;
                nxt_bus_st = BUS_DONE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            bus_st_ff <= BUS_IDLE;
            req_ff    <= '0;
            hrdata_ff <= 32'h0000_0000;
        end else if (clk_en) begin
            bus_st_ff <= nxt_bus_st;
            req_ff    <= nxt_req;
            hrdata_ff <= nxt_hrdata;
        end
    end

    // ==========================================================
    // message RAM and its read port arbitration
    assign scan_addr = AW'(start_ff + {idx_ff, 1'b0}) +
                       AW'(scan_st_ff == SCAN_FETCH1);
    assign scan_rd   = ((scan_st_ff == SCAN_FETCH0) && !bus_ram_req)
                       || (scan_st_ff == SCAN_FETCH1);
    assign ram_raddr = bus_ram_take ? req_ff.addr[AW+1:2] : scan_addr;

    filter_ram #(
        .DATA_W (32),
        .DEPTH  (RAM_DEPTH)
    ) u_ram (
        .clk_sys    (clk_sys),
        .clk_en     (clk_en),
        .wr_en      (reg_wr && is_ram),
        .wr_addr    (req_ff.addr[AW+1:2]),
        .wr_data    (hwdata),
        .rd_en      (bus_ram_take || scan_rd),
        .rd_addr    (ram_raddr),
        .rd_data_ff (ram_rdata)
    );

    // ==========================================================
    // element matching
    function automatic logic masked_eq(input logic [28:0] a,
                                       input logic [28:0] b,
                                       input logic [28:0] m);
        return (a & m) == (b & m);
    endfunction

    function automatic logic elem_match(input element_type e,
                                        input logic [28:0] id,
                                        input logic [28:0] gm);
        logic [28:0] mid;
        logic [28:0] lo;
        logic [28:0] hi;
        mid = id & gm;
        lo  = e.ext_first_identifier;
        hi  = e.ext_second_identifier;
        if (e.ext_element_config == `EIDF_CFG_DISABLED) begin
            return 1'b0;
        end
        if (e.ext_element_config == `EIDF_CFG_BUFFER) begin
            return masked_eq(id, lo, gm);
        end
        unique case (e.ext_match_type)
            `EIDF_TYPE_RANGE:     return mid >= lo && mid <= hi;
            `EIDF_TYPE_DUAL:      return mid == lo || mid == hi;
            `EIDF_TYPE_CLASSIC:   return masked_eq(mid, lo, hi);
            `EIDF_TYPE_RANGE_RAW: return id >= lo && id <= hi;
        endcase
    endfunction

    assign elem     = {w0_ff, ram_rdata};
    assign hit      = elem_match(elem, id_ff, gmask_ff);
    assign size_eff = (size_ff > 7'(NUM_ELEMENTS)) ? 7'(NUM_ELEMENTS)
                                                    : size_ff;

    // decode what a matching element does with the frame
    always_comb begin
        action            = '0;
        action.matched    = 1'b1;
        action.accepted   = 1'b1;
        action.index      = idx_ff[5:0];
        unique case (elem.ext_element_config)
            `EIDF_CFG_DISABLED, `EIDF_CFG_FIFO0: begin
                action.dest = DEST_FIFO0;
            end
            `EIDF_CFG_FIFO1: begin
                action.dest = DEST_FIFO1;
            end
            `EIDF_CFG_REJECT: begin
                action.accepted = 1'b0;
            end
            `EIDF_CFG_PRIO: begin
                action.priority_hit = 1'b1;
                action.accepted     = 1'b0;
            end
            `EIDF_CFG_PRIO_FIFO0: begin
                action.priority_hit = 1'b1;
                action.dest         = DEST_FIFO0;
            end
            `EIDF_CFG_PRIO_FIFO1: begin
                action.priority_hit = 1'b1;
                action.dest         = DEST_FIFO1;
            end
            `EIDF_CFG_BUFFER: begin
                action.dest = dest_type'({1'b0, elem.ext_second_identifier
                    [`EIDF_ID2_KIND_MSB:`EIDF_ID2_KIND_LSB]} + 3'h3);
                action.buf_offset = elem.ext_second_identifier
                    [`EIDF_ID2_OFS_MSB:`EIDF_ID2_OFS_LSB];
            end
        endcase
    end

    // ==========================================================
    // element scanner
    assign id_ready     = (scan_st_ff == SCAN_IDLE);
    assign result_valid = result_valid_ff;
    assign result       = result_ff;
    assign filter_event = event_ff;

    always_comb begin
        nxt_scan_st      = scan_st_ff;
        nxt_idx          = idx_ff;
        nxt_id           = id_ff;
        nxt_w0           = w0_ff;
        nxt_result       = result_ff;
        nxt_result_valid = 1'b0;
        nxt_event        = 3'h0;
        nxt_hpm_status   = hpm_status_ff;
        evt_set          = '0;
        unique case (scan_st_ff)
            SCAN_IDLE: begin
                if (id_valid) begin
                    nxt_id      = rx_id;
                    nxt_idx     = 7'h00;
                    nxt_scan_st = SCAN_FETCH0;
                end
            end
            SCAN_FETCH0: begin
                if (idx_ff >= size_eff) begin
                    nxt_result       = '0;
                    nxt_result_valid = 1'b1;
                    evt_set[`EIDF_IRQ_DONE] = 1'b1;
                    evt_set[`EIDF_IRQ_MISS] = 1'b1;
                    nxt_scan_st      = SCAN_IDLE;
                end else if (!bus_ram_req) begin
                    nxt_scan_st = SCAN_FETCH1;
                end
            end
            SCAN_FETCH1: begin
                nxt_w0      = ram_rdata;
                nxt_scan_st = SCAN_CHECK;
            end
            SCAN_CHECK: begin
                if (hit) begin
                    nxt_result       = action;
                    nxt_result_valid = 1'b1;
                    evt_set[`EIDF_IRQ_DONE] = 1'b1;
                    nxt_scan_st      = SCAN_IDLE;
                    if (action.priority_hit) begin
                        evt_set[`EIDF_IRQ_HPM] = 1'b1;
                        nxt_hpm_status[5:0] = idx_ff[5:0];
                        nxt_hpm_status[7:6] =
                            (action.dest == DEST_FIFO0) ? `EIDF_MSI_FIFO0 :
                            (action.dest == DEST_FIFO1) ? `EIDF_MSI_FIFO1 :
                                                          `EIDF_MSI_NONE;
                    end
                    if (elem.ext_element_config == `EIDF_CFG_BUFFER) begin
                        nxt_event = elem.ext_second_identifier
                            [`EIDF_ID2_EVT_MSB:`EIDF_ID2_EVT_LSB];
                    end
                end else begin
                    nxt_idx     = idx_ff + 7'h01;
                    nxt_scan_st = SCAN_FETCH0;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            scan_st_ff      <= SCAN_IDLE;
            idx_ff          <= 7'h00;
            id_ff           <= 29'h0000_0000;
            w0_ff           <= 32'h0000_0000;
            result_ff       <= '0;
            result_valid_ff <= 1'b0;
            event_ff        <= 3'h0;
        end else if (clk_en) begin
            scan_st_ff      <= nxt_scan_st;
            idx_ff          <= nxt_idx;
            id_ff           <= nxt_id;
            w0_ff           <= nxt_w0;
            result_ff       <= nxt_result;
            result_valid_ff <= nxt_result_valid;
            event_ff        <= nxt_event;
        end
    end

    // ==========================================================
    // control and status registers, interrupt
    always_comb begin
        unique case (req_ff.addr)
            `EIDF_OFS_LIST_CFG:    reg_rdata = {9'h000, size_ff,
                                                8'h00, start_ff};
            `EIDF_OFS_GLOBAL_MASK: reg_rdata = {3'h0, gmask_ff};
            `EIDF_OFS_IRQ_STATUS:  reg_rdata = 32'(ist_ff);
            `EIDF_OFS_IRQ_ENABLE:  reg_rdata = 32'(ien_ff);
            `EIDF_OFS_HPM_STATUS:  reg_rdata = 32'(hpm_status_ff);
            `EIDF_OFS_LAST_RESULT: reg_rdata = 32'(result_ff);
            default:               reg_rdata = 32'h0000_0000;
        endcase
    end

    always_comb begin
        nxt_start = start_ff;
        nxt_size  = size_ff;
        nxt_gmask = gmask_ff;
        nxt_ien   = ien_ff;
        nxt_ist   = ist_ff;
        if (reg_wr && !is_ram) begin
            unique case (req_ff.addr)
                `EIDF_OFS_LIST_CFG: begin
                    nxt_start = hwdata[`EIDF_LCFG_START_MSB:
                                       `EIDF_LCFG_START_LSB];
                    nxt_size  = hwdata[`EIDF_LCFG_SIZE_MSB:
                                       `EIDF_LCFG_SIZE_LSB];
                end
                `EIDF_OFS_GLOBAL_MASK: nxt_gmask = hwdata[28:0];
                `EIDF_OFS_IRQ_ENABLE:  nxt_ien = hwdata[`EIDF_IRQ_BITS-1:0];
                `EIDF_OFS_IRQ_STATUS:
                    nxt_ist = ist_ff & ~hwdata[`EIDF_IRQ_BITS-1:0];
                default: nxt_start = start_ff;
            endcase
        end
        // a new event wins over a clear in the same cycle
        nxt_ist = nxt_ist | evt_set;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            start_ff      <= `EIDF_RST_START;
            size_ff       <= `EIDF_RST_SIZE;
            gmask_ff      <= `EIDF_RST_GLOBAL_MASK;
            ien_ff        <= '0;
            ist_ff        <= '0;
            hpm_status_ff <= 8'h00;
            irq           <= 1'b0;
        end else if (clk_en) begin
            start_ff      <= nxt_start;
            size_ff       <= nxt_size;
            gmask_ff      <= nxt_gmask;
            ien_ff        <= nxt_ien;
            ist_ff        <= nxt_ist;
            hpm_status_ff <= nxt_hpm_status;
            irq           <= |(nxt_ist & nxt_ien);
        end
    end

endmodule

// ### tb/eidf_chk.sv
/* scan result checker for the extended id filter.
   assumes clk_en held high; bound to the filter top. */
`timescale 1ns/100ps
module eidf_chk
    import eidf_pkg::*;
(
    input wire logic              clk_sys,
    input wire logic              reset_n,
    input wire logic              id_valid,
    input wire logic              id_ready,
    input wire logic              result_valid,
    input wire filter_result_type result,
    input wire logic [2:0]        filter_event
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // ==========================================
    // scan handshake and result coding
    take_done_a: assert property (id_valid && id_ready |-> ##[2:400]
        result_valid) else $error("scan did not finish");
    take_busy_a: assert property (id_valid && id_ready |=>
        !id_ready) else $error("request taken while busy");
    one_pulse_a: assert property (result_valid |=> !result_valid)
        else $error("result pulse too long");
    reject_plain_a: assert property (result_valid && result.matched
        && !result.priority_hit && result.dest == DEST_NONE
        |-> !result.accepted) else $error("reject accepted");
    prio_flag_a: assert property (result_valid && result.priority_hit
        |-> result.matched && result.dest <= DEST_FIFO1)
        else $error("priority flag bad");
    buf_accept_a: assert property (result_valid &&
        result.dest >= DEST_RXBUF |-> result.matched && result.accepted
        && !result.priority_hit) else $error("buffer result bad");
    event_buf_a: assert property (filter_event != 3'h0 |->
        result_valid && result.dest >= DEST_RXBUF)
        else $error("stray filter event");
    miss_zero_a: assert property (result_valid && !result.matched
        |-> result == '0 && filter_event == 3'h0)
        else $error("miss result not clear");
endmodule

bind extended_id_acceptance_filter eidf_chk eidf_chk_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .id_valid(id_valid),
    .id_ready(id_ready), .result_valid(result_valid),
    .result(result), .filter_event(filter_event));

// ### tb/rx_source.sv
/* receive path model handing identifiers to the filter.
   assumes the filter samples id_valid on clk_sys rising edges. */
`timescale 1ns/100ps
module rx_source (
    input  wire logic        clk_sys,
    input  wire logic        id_ready,
    output logic             id_valid,
    output logic      [28:0] rx_id
);
    initial begin
        id_valid = 1'b0;
        rx_id = 29'h0000_0000;
    end
    // ==========================================
    // one identifier, held until taken
    task send(input logic [28:0] id);
        @(posedge clk_sys);
        id_valid <= 1'b1;
        rx_id <= id;
        do @(posedge clk_sys); while (id_ready !== 1'b1);
        id_valid <= 1'b0;
        // released lines must not keep showing the old id
        rx_id <= ~id;
    endtask
endmodule

// ### tb/testbench.sv
/* self-checking bench: ahb register and ram access, identifier scans.
   assumes the filter top, its package and the rx_source model. */
`timescale 1ns/100ps
module testbench;
    import eidf_pkg::*;
    logic              clk_sys = 1'b0;
    logic              reset_n = 1'b0;
    logic              hsel = 1'b0;
    logic              hwrite = 1'b0;
    logic        [1:0] htrans = 2'h0;
    logic       [31:0] haddr = 32'h0000_0000;
    logic       [31:0] hwdata = 32'h0000_0000;
    logic       [31:0] q;
    wire logic         hreadyout, hresp, id_valid, id_ready;
    wire logic         result_valid, irq;
    wire logic  [31:0] hrdata;
    wire logic  [28:0] rx_id;
    wire logic   [2:0] filter_event;
    filter_result_type result;
    int                n_errors = 0, n_compared = 0, cycles = 0;

    always #5 clk_sys = ~clk_sys;

    extended_id_acceptance_filter extended_id_acceptance_filter_i (
        .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(1'b1),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .id_valid(id_valid), .rx_id(rx_id), .id_ready(id_ready),
        .result_valid(result_valid), .result(result),
        .filter_event(filter_event), .irq(irq));
    rx_source rx_source_i (.clk_sys(clk_sys), .id_ready(id_ready),
        .id_valid(id_valid), .rx_id(rx_id));

    // ==========================================
    // checking and bus tasks
    task end_of_test;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task chk(input string s, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0_0000, a};
        hwrite <= w;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task rd(input string s, input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk(s, q, e);
        chk("response", {31'h0, hresp}, 32'h0000_0000);
    endtask
    // element n sits at list start 0x10 words plus twice n
    task elem(input int n, input logic [2:0] c, input logic [1:0] t,
              input logic [28:0] i1, i2);
        bus(1'b1, 12'h440 + 12'(8 * n), {c, i1});
        bus(1'b1, 12'h444 + 12'(8 * n), {t, 1'b0, i2});
    endtask
    task scan(input logic [28:0] id, input logic [17:0] e,
              input logic [2:0] ev);
        rx_source_i.send(id);
        do @(posedge clk_sys); while (result_valid !== 1'b1);
        chk("result", {14'h0000, result}, {14'h0000, e});
        chk("filter event", {29'h0, filter_event}, {29'h0, ev});
    endtask
    task irq_is(input logic e);
        repeat (2) @(posedge clk_sys);
        chk("irq", {31'h0, irq}, {31'h0, e});
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            end_of_test;
        end
    end

    // ==========================================
    // test sequence
    initial begin
        repeat (6) @(posedge clk_sys);
        reset_n <= 1'b1;
        rd("global mask", 12'h004, 32'h1FFF_FFFF);
        rd("list config", 12'h000, 32'h0000_0000);
        bus(1'b1, 12'h020, 32'hFFFF_FFFF);
        rd("unmapped", 12'h020, 32'h0000_0000);
        $display("test registers done");
        elem(0, 3'h0, 2'h1, 29'h100, 29'h100);
        elem(1, 3'h3, 2'h1, 29'h200, 29'h1500);
        elem(2, 3'h1, 2'h0, 29'h1000, 29'h1FFF);
        elem(3, 3'h2, 2'h2, 29'hAB_0000, 29'hFF_0000);
        elem(4, 3'h6, 2'h3, 29'h1F00_0000, 29'h1F00_00FF);
        elem(5, 3'h7, 2'h1, 29'h555_5555, 29'h343);
        bus(1'b1, 12'h000, 32'h0006_0010);
        scan(29'h100, 18'h0_0000, 3'h0);
        scan(29'h200, {3'h4, DEST_NONE, 6'h01, 6'h00}, 3'h0);
        scan(29'h1500, {3'h4, DEST_NONE, 6'h01, 6'h00}, 3'h0);
        scan(29'h1FFF, {3'h6, DEST_FIFO0, 6'h02, 6'h00}, 3'h0);
        scan(29'h2000, 18'h0_0000, 3'h0);
        scan(29'hAB_1234, {3'h6, DEST_FIFO1, 6'h03, 6'h00}, 3'h0);
        scan(29'h1F00_00FF, {3'h7, DEST_FIFO1, 6'h04, 6'h00}, 3'h0);
        irq_is(1'b0);
        scan(29'h555_5555, {3'h6, DEST_DEBUG_A, 6'h05, 6'h03}, 3'h5);
        scan(29'h555_5554, 18'h0_0000, 3'h0);
        $display("test element codes done");
        rd("irq status", 12'h008, 32'h0000_0007);
        bus(1'b1, 12'h008, 32'h0000_0007);
        bus(1'b1, 12'h00C, 32'h0000_0001);
        scan(29'h1F00_0000, {3'h7, DEST_FIFO1, 6'h04, 6'h00}, 3'h0);
        irq_is(1'b1);
        rd("priority status", 12'h010, 32'h0000_00C4);
        bus(1'b1, 12'h008, 32'h0000_0007);
        irq_is(1'b0);
        rd("irq status", 12'h008, 32'h0000_0000);
        $display("test interrupt done");
        bus(1'b1, 12'h004, 32'h0FFF_FFFF);
        scan(29'h1000_1000, {3'h6, DEST_FIFO0, 6'h02, 6'h00}, 3'h0);
        scan(29'h1555_5555, {3'h6, DEST_DEBUG_A, 6'h05, 6'h03}, 3'h5);
        scan(29'h1F00_0010, {3'h7, DEST_FIFO1, 6'h04, 6'h00}, 3'h0);
        rd("last result", 12'h014, 32'h0003_A100);
        $display("test global mask done");
        end_of_test;
    end
endmodule
